// ### rtl/vbsr_cfg.svh
`ifndef VBSR_CFG_SVH
`define VBSR_CFG_SVH

// register offsets on the host port
`define VBSR_ADDR_INTCFG   8'hC2
`define VBSR_ADDR_RAMDATA  8'hC3
`define VBSR_ADDR_RAMLO    8'hC4
`define VBSR_ADDR_RAMHI    8'hC5
`define VBSR_ADDR_STATUS   8'hC6
`define VBSR_ADDR_WORDCNT  8'hC7

// interrupt pin config fields and reset
`define VBSR_INTCFG_POL    0
`define VBSR_INTCFG_ACT    1
`define VBSR_INTCFG_PIXOE  2
`define VBSR_INTCFG_RST    8'h04

// configuration ram geometry and reset values
`define VBSR_RAM_BYTES     512
`define VBSR_RAM_AW        9
`define VBSR_SLOT_BYTES    16
`define VBSR_SLOT_COUNT    32
`define VBSR_STD_SLOTS     12
`define VBSR_CUSTOM1_BASE  9'h1B0
`define VBSR_CUSTOM2_BASE  9'h1D0
`define VBSR_PTR_RST       9'h00F
`define VBSR_RAMDATA_RST   8'hDC
`define VBSR_PTR_STEP      9'h001
`define VBSR_RAMHI_BIT     0

// status register fields
`define VBSR_ST_FULL       7
`define VBSR_ST_EMPTY      6
`define VBSR_ST_SVC_W      6

// fifo defaults
`define VBSR_FIFO_BYTES    256
`define VBSR_WORD_SHIFT    1

`endif

// ### rtl/vbsr_pkg.sv
package vbsr_pkg;

  // one decoded access from the serial host port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vbsr_host_req_t;

  // one captured blanking line offered to the fifo
  typedef struct packed {
    logic       req;
    logic [8:0] bytes;
  } vbsr_line_req_t;

  // line admission outcome
  typedef enum logic [1:0] {
    VBSR_LINE_IDLE   = 2'b00,
    VBSR_LINE_ACCEPT = 2'b01,
    VBSR_LINE_REJECT = 2'b10
  } vbsr_line_res_t;

endpackage

// ### rtl/vbsr_cfg_ram.sv
`timescale 1ns/1ps
`include "vbsr_cfg.svh"

module vbsr_cfg_ram
  import vbsr_pkg::*;
#(
  parameter int AW = `VBSR_RAM_AW
)(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic          load_lo_i,
  input  wire logic          load_hi_i,
  output logic      [7:0]    rdata_o,
  output logic      [AW-1:0] ptr_o
);

  // 512 bytes as 32 slots of 16
  // slots 12 and up include custom bases
  logic [7:0] mem [0:(1<<AW)-1];

  // byte under the counter, read by the host data port
  assign rdata_o = mem[ptr_o];

  always_ff @(posedge clk_i)
  begin
    if (ce_i && wr_i)
    begin
      mem[ptr_o] <= wdata_i;
    end
  end

  // address counter: load low/high, step on every data access
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ptr_o <= `VBSR_PTR_RST;
    end
    else if (ce_i)
    begin
      if (load_lo_i)
      begin
        ptr_o[7:0] <= wdata_i;
      end
      else if (load_hi_i)
      begin
        ptr_o[AW-1] <= wdata_i[`VBSR_RAMHI_BIT];
      end
      else if (wr_i || rd_i)
      begin
        ptr_o <= ptr_o + AW'(`VBSR_PTR_STEP);
      end
    end
  end

  a_ptr_step_access: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && (wr_i || rd_i) && !load_lo_i && !load_hi_i
    |=> ptr_o == AW'($past(ptr_o) + AW'(1)))
    else $error("config counter did not step");

  a_ptr_load_low: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && load_lo_i |=> ptr_o[7:0] == $past(wdata_i))
    else $error("config counter low byte not loaded");

endmodule // vbsr_cfg_ram

// ### rtl/vbsr_fifo_acct.sv
`timescale 1ns/1ps
`include "vbsr_cfg.svh"

module vbsr_fifo_acct
  import vbsr_pkg::*;
#(
  parameter int DEPTH = `VBSR_FIFO_BYTES,
  parameter int CW    = $clog2(DEPTH + 1)
)(
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  input  wire logic           ce_i,
  input  wire vbsr_line_req_t line_i,
  input  wire logic           pop_i,
  input  wire logic           flush_i,
  output vbsr_line_res_t      res_o,
  output logic      [CW-1:0]  fill_o
);

  int          need;
  int          room;
  logic        fits;
  logic        popping;

  // whole line must fit remaining space
  always_comb
  begin
    popping = pop_i && (fill_o != '0);
    // kept wide so a long line never wraps into a small one
    need    = int'(line_i.bytes);
    room    = DEPTH - int'(fill_o);
    fits    = need <= room;
  end

  // byte fill level of the fifo
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fill_o <= '0;
    end
    else if (ce_i)
    begin
      if (flush_i)
      begin
        fill_o <= '0;
      end
      else if (line_i.req && fits)
      begin
        fill_o <= CW'(fill_o + CW'(line_i.bytes) - CW'(popping));
      end
      else
      begin
        fill_o <= CW'(fill_o - CW'(popping));
      end
    end
  end

  // one-cycle admission result per offered line
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      res_o <= VBSR_LINE_IDLE;
    end
    else if (ce_i)
    begin
      if (line_i.req && !flush_i)
      begin
        res_o <= fits ? VBSR_LINE_ACCEPT : VBSR_LINE_REJECT;
      end
      else
      begin
        res_o <= VBSR_LINE_IDLE;
      end
    end
  end

  a_discard_no_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && line_i.req && !fits && !flush_i && !pop_i
    |=> fill_o == $past(fill_o) && res_o == VBSR_LINE_REJECT)
    else $error("oversized line altered the fifo");

  a_fit_line_written: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && line_i.req && fits && !flush_i && !pop_i
    |=> fill_o == CW'($past(fill_o) + CW'($past(line_i.bytes))))
    else $error("fitting line was not written");

endmodule // vbsr_fifo_acct

// ### rtl/vbsr_top.sv
`timescale 1ns/1ps
`include "vbsr_cfg.svh"

// Behaviour
// - pixel enable clear tristates pixel pins
// - bit 1 reads pin active, ignores writes
// - bit 0 picks polarity, low default
// - active low: pull low, else release
// - active high: drive high, else low
// - config memory: 32 slots of 16 bytes
// - data port accesses counter byte, increments
// - address registers load 9-bit start
// - status flags other than bit 6 clear only by one-write
// - bit 6 shows fifo empty live
// - line not fitting is dropped, flagged
// - later fitting lines still written
// - per-service sticky availability flags
// - word count reports two-byte words held
// - pin asserts when status and enable
module vbsr_top
  import vbsr_pkg::*;
#(
  parameter int FIFO_BYTES = `VBSR_FIFO_BYTES
)(
  input  wire logic           MCLK_I,
  input  wire logic           ARST_N_I,
  input  wire logic           CE_I,
  input  wire vbsr_host_req_t HOST_REQ_I,
  output logic      [7:0]     HOST_RDATA_O,
  input  wire logic [7:0]     IRQ_STATUS_I,
  input  wire logic [7:0]     IRQ_ENABLE_I,
  output logic                INTR_O,
  output logic                INTR_OE_O,
  input  wire logic           PIX_COND_I,
  output logic                PIX_OE_O,
  input  wire logic [5:0]     SVC_AVAIL_I,
  input  wire vbsr_line_req_t LINE_I,
  input  wire logic           FIFO_POP_I,
  input  wire logic           FIFO_FLUSH_I,
  output logic                LINE_ACCEPT_O,
  output logic                LINE_REJECT_O
);

  localparam int CW = $clog2(FIFO_BYTES + 1);

  logic             rst_meta;
  logic             rst_n;
  logic             int_pol;
  logic             int_act;
  logic             next_act;
  logic             pix_oe;
  logic [5:0]       svc_flags;
  logic             full_err;
  logic [7:0]       ram_rdata;
  logic [8:0]       ram_ptr;
  logic [CW-1:0]    fifo_fill;
  logic             fifo_empty;
  logic [7:0]       word_cnt;
  vbsr_line_res_t   line_res;
  logic             wr_intcfg;
  logic             wr_status;
  logic             acc_data_wr;
  logic             acc_data_rd;
  logic [7:0]       next_rdata;

  // register offset match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // reset release through two flops
  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // host access decode
  always_comb
  begin
    wr_intcfg   = HOST_REQ_I.wr && hit(HOST_REQ_I.addr, `VBSR_ADDR_INTCFG);
    wr_status   = HOST_REQ_I.wr && hit(HOST_REQ_I.addr, `VBSR_ADDR_STATUS);
    acc_data_wr = HOST_REQ_I.wr
                  && hit(HOST_REQ_I.addr, `VBSR_ADDR_RAMDATA);
    acc_data_rd = HOST_REQ_I.rd && !HOST_REQ_I.wr
                  && hit(HOST_REQ_I.addr, `VBSR_ADDR_RAMDATA);
    // pin level from status and enable
    next_act    = |(IRQ_STATUS_I & IRQ_ENABLE_I);
    fifo_empty  = (fifo_fill == '0);
    word_cnt    = 8'(fifo_fill >> `VBSR_WORD_SHIFT);
  end

  // writable interrupt-config bits; active bit is not writable
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_pol <= 1'(`VBSR_INTCFG_RST >> `VBSR_INTCFG_POL);
      pix_oe  <= 1'(`VBSR_INTCFG_RST >> `VBSR_INTCFG_PIXOE);
    end
    else if (CE_I && wr_intcfg)
    begin
      int_pol <= HOST_REQ_I.wdata[`VBSR_INTCFG_POL];
      pix_oe  <= HOST_REQ_I.wdata[`VBSR_INTCFG_PIXOE];
    end
  end

  // interrupt pin drive and its read-back copy
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_act   <= 1'b0;
      INTR_O    <= 1'b0;
      INTR_OE_O <= 1'b0;
    end
    else if (CE_I)
    begin
      int_act <= next_act;
      if (int_pol)
      begin
        INTR_O    <= next_act;
        INTR_OE_O <= 1'b1;
      end
      else
      begin
        INTR_O    <= 1'b0;
        INTR_OE_O <= next_act;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PIX_OE_O <= 1'b0;
    end
    else if (CE_I)
    begin
      PIX_OE_O <= pix_oe && PIX_COND_I;
    end
  end

  // sticky flags, set beats one-write clear
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      svc_flags <= '0;
    end
    else if (CE_I)
    begin
      svc_flags <= SVC_AVAIL_I | (svc_flags
                   & ~({6{wr_status}}
                   & HOST_REQ_I.wdata[`VBSR_ST_SVC_W-1:0]));
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      full_err <= 1'b0;
    end
    else if (CE_I)
    begin
      if (line_res == VBSR_LINE_REJECT)
      begin
        full_err <= 1'b1;
      end
      else if (wr_status && HOST_REQ_I.wdata[`VBSR_ST_FULL])
      begin
        full_err <= 1'b0;
      end
    end
  end

  // line admission result to the capture path
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      LINE_ACCEPT_O <= 1'b0;
      LINE_REJECT_O <= 1'b0;
    end
    else if (CE_I)
    begin
      LINE_ACCEPT_O <= (line_res == VBSR_LINE_ACCEPT);
      LINE_REJECT_O <= (line_res == VBSR_LINE_REJECT);
    end
  end

  // read data mux, registered one cycle after the read
  always_comb
  begin
    case (HOST_REQ_I.addr)
      `VBSR_ADDR_INTCFG:
        next_rdata = {5'h00, pix_oe, int_act, int_pol};
      `VBSR_ADDR_RAMDATA:
        next_rdata = ram_rdata;
      `VBSR_ADDR_RAMLO:
        next_rdata = ram_ptr[7:0];
      `VBSR_ADDR_RAMHI:
        next_rdata = {7'h00, ram_ptr[8]};
      `VBSR_ADDR_STATUS:
        next_rdata = {full_err, fifo_empty, svc_flags};
      `VBSR_ADDR_WORDCNT:
        next_rdata = word_cnt;
      default:
        next_rdata = 8'h00;
    endcase
  end

  // host read data register
  always_ff @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      HOST_RDATA_O <= `VBSR_RAMDATA_RST;
    end
    else if (CE_I && HOST_REQ_I.rd && !HOST_REQ_I.wr)
    begin
      HOST_RDATA_O <= next_rdata;
    end
  end

  // configuration memory with its address counter
  vbsr_cfg_ram #(
    .AW (`VBSR_RAM_AW)
  ) u_cfg_ram (
    .clk_i     (MCLK_I),
    .rst_n_i   (rst_n),
    .ce_i      (CE_I),
    .wr_i      (acc_data_wr),
    .rd_i      (acc_data_rd),
    .wdata_i   (HOST_REQ_I.wdata),
    .load_lo_i (HOST_REQ_I.wr && hit(HOST_REQ_I.addr, `VBSR_ADDR_RAMLO)),
    .load_hi_i (HOST_REQ_I.wr && hit(HOST_REQ_I.addr, `VBSR_ADDR_RAMHI)),
    .rdata_o   (ram_rdata),
    .ptr_o     (ram_ptr)
  );

  // fifo space accounting and line admission
  vbsr_fifo_acct #(
    .DEPTH (FIFO_BYTES),
    .CW    (CW)
  ) u_fifo_acct (
    .clk_i   (MCLK_I),
    .rst_n_i (rst_n),
    .ce_i    (CE_I),
    .line_i  (LINE_I),
    .pop_i   (FIFO_POP_I),
    .flush_i (FIFO_FLUSH_I),
    .res_o   (line_res),
    .fill_o  (fifo_fill)
  );

  a_pixel_hiz: assert property (
    @(posedge MCLK_I) disable iff (!rst_n)
    CE_I && !pix_oe |=> !PIX_OE_O)
    else $error("pixel pins driven while disabled");

  a_active_ro: assert property (
    @(posedge MCLK_I) disable iff (!rst_n)
    CE_I |=> int_act == $past(next_act))
    else $error("active bit does not follow the pin");

  a_pol_write: assert property (
    @(posedge MCLK_I) disable iff (!rst_n)
    CE_I && wr_intcfg
    |=> int_pol == $past(HOST_REQ_I.wdata[`VBSR_INTCFG_POL]))
    else $error("polarity bit not written");

  a_open_drain_low: assert property (
    @(posedge MCLK_I) disable iff (!rst_n)
    CE_I && !int_pol |=> !INTR_O && INTR_OE_O == int_act)
    else $error("active-low pin not open drain");

  a_push_pull_high: assert property (
    @(posedge MCLK_I) disable iff (!rst_n)
    CE_I && int_pol && !wr_intcfg ##1 CE_I
    |=> INTR_OE_O && INTR_O == int_act)
    else $error("active-high pin not push-pull");

  a_sticky_hold: assert property (
    @(posedge MCLK_I) disable iff (!rst_n)
    CE_I && full_err
    && !(wr_status && HOST_REQ_I.wdata[`VBSR_ST_FULL]) |=> full_err)
    else $error("full error cleared without a one-write");

  a_empty_live: assert property (
    @(posedge MCLK_I) disable iff (!rst_n)
    HOST_REQ_I.rd && !HOST_REQ_I.wr && CE_I
    && hit(HOST_REQ_I.addr, `VBSR_ADDR_STATUS)
    |=> HOST_RDATA_O[`VBSR_ST_EMPTY] == $past(fifo_fill == '0))
    else $error("empty bit not live");

  a_full_flag_set: assert property (
    @(posedge MCLK_I) disable iff (!rst_n)
    CE_I && line_res == VBSR_LINE_REJECT |=> full_err && LINE_REJECT_O)
    else $error("discard did not raise the full error");

  a_svc_set_wins: assert property (
    @(posedge MCLK_I) disable iff (!rst_n)
    CE_I && SVC_AVAIL_I[5] |=> svc_flags[5])
    else $error("teletext flag not set by capture");

  a_word_count: assert property (
    @(posedge MCLK_I) disable iff (!rst_n)
    HOST_REQ_I.rd && !HOST_REQ_I.wr && CE_I
    && hit(HOST_REQ_I.addr, `VBSR_ADDR_WORDCNT)
    |=> HOST_RDATA_O == 8'($past(fifo_fill) >> `VBSR_WORD_SHIFT))
    else $error("word count is not half the byte fill");

  a_ptr_wrap: assert property (
    @(posedge MCLK_I) disable iff (!rst_n)
    CE_I && acc_data_wr && ram_ptr == 9'h1FF |=> ram_ptr == 9'h000)
    else $error("config counter did not wrap");

endmodule // vbsr_top

// ### tb/vbsr_host_model.sv
`timescale 1ns/1ps

// host processor side of the register port, one access per write_reg or read_reg call
module vbsr_host_model
  import vbsr_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic [7:0]     rdata_i,
  output vbsr_host_req_t      req_o
);
  initial req_o = '0;

  // request held across its taking edge, then released with junk fields
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    #1;
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = rdata_i;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(1'b1, a, d, q);
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
    access(1'b0, a, 8'h00, q);
  endtask

  task automatic park_line_modes();
    for (int i = 8'hD0; i <= 8'hFB; i++)
      write_reg(i[7:0], 8'hFF);
    write_reg(8'hCF, 8'h00);
  endtask

  task automatic load_caption_slot();
    write_reg(8'hC4, 8'hF0);
    write_reg(8'hC5, 8'h00);
    write_reg(8'hC3, 8'hAA);
    write_reg(8'hC3, 8'h2A);
    write_reg(8'hC3, 8'hFF);
    write_reg(8'hC3, 8'h3F);
  endtask
endmodule // vbsr_host_model

// ### tb/vbsr_top_tb.sv
`timescale 1ns/1ps

module vbsr_top_tb;
  import vbsr_pkg::*;
  localparam int FB = 16;
  logic           mclk, arst_n, pix_cond, pop, flush, ce;
  logic           acc, rej, intr, intr_oe, pix_oe;
  logic [7:0]     rdata, st, en, q;
  logic [5:0]     svc;
  vbsr_host_req_t req;
  vbsr_line_req_t line;
  int             bad_count = 0;
  int             samples_checked = 0;
  logic [7:0]     cc [4] = '{8'hAA, 8'h2A, 8'hFF, 8'h3F};

  vbsr_top #(.FIFO_BYTES(FB)) dut_u (
    .MCLK_I(mclk), .ARST_N_I(arst_n), .CE_I(ce), .HOST_REQ_I(req),
    .HOST_RDATA_O(rdata), .IRQ_STATUS_I(st), .IRQ_ENABLE_I(en),
    .INTR_O(intr), .INTR_OE_O(intr_oe), .PIX_COND_I(pix_cond),
    .PIX_OE_O(pix_oe), .SVC_AVAIL_I(svc), .LINE_I(line),
    .FIFO_POP_I(pop), .FIFO_FLUSH_I(flush), .LINE_ACCEPT_O(acc),
    .LINE_REJECT_O(rej)
  );
  vbsr_host_model host_u (.clk_i(mclk), .rdata_i(rdata), .req_o(req));

  // free running clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    host_u.read_reg(a, q);
    check(what, q, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic set_ptr(input logic [8:0] p);
    host_u.write_reg(8'hC4, p[7:0]);
    host_u.write_reg(8'hC5, {7'h00, p[8]});
  endtask

  task automatic test_reset_values();
    rd_chk("intcfg", 8'hC2, 8'h04);
    rd_chk("ptr lo", 8'hC4, 8'h0F);
    rd_chk("ptr hi", 8'hC5, 8'h00);
    rd_chk("status", 8'hC6, 8'h40);
    rd_chk("words", 8'hC7, 8'h00);
    check("pix oe", {7'h00, pix_oe}, 8'h01);
  endtask

  task automatic test_cfg_ram();
    host_u.park_line_modes();
    host_u.load_caption_slot();
    rd_chk("ptr after load", 8'hC4, 8'hF4);
    set_ptr(9'h0F0);
    for (int i = 0; i < 4; i++)
      rd_chk("caption byte", 8'hC3, cc[i]);
    set_ptr(9'h1B0);
    host_u.write_reg(8'hC3, 8'h5A);
    set_ptr(9'h1B0);
    rd_chk("custom slot", 8'hC3, 8'h5A);
    set_ptr(9'h1FE);
    host_u.write_reg(8'hC3, 8'h11);
    host_u.write_reg(8'hC3, 8'h22);
    host_u.write_reg(8'hC3, 8'h33);
    rd_chk("wrapped lo", 8'hC4, 8'h01);
    rd_chk("wrapped hi", 8'hC5, 8'h00);
    set_ptr(9'h1FE);
    rd_chk("byte 1FE", 8'hC3, 8'h11);
    rd_chk("byte 1FF", 8'hC3, 8'h22);
    rd_chk("byte 000", 8'hC3, 8'h33);
  endtask

  task automatic test_intr_pin();
    st = 8'h01;
    en = 8'h02;
    ticks(2);
    check("no overlap oe", {7'h00, intr_oe}, 8'h00);
    en = 8'h03;
    ticks(2);
    check("low oe", {7'h00, intr_oe}, 8'h01);
    check("low level", {7'h00, intr}, 8'h00);
    rd_chk("active bit", 8'hC2, 8'h06);
    en = 8'h00;
    ticks(2);
    check("low release", {7'h00, intr_oe}, 8'h00);
    host_u.write_reg(8'hC2, 8'h03);
    ticks(2);
    check("high idle oe", {7'h00, intr_oe}, 8'h01);
    check("high idle lvl", {7'h00, intr}, 8'h00);
    check("pix off", {7'h00, pix_oe}, 8'h00);
    rd_chk("ro bit", 8'hC2, 8'h01);
    en = 8'h01;
    ticks(2);
    check("high active", {7'h00, intr}, 8'h01);
    rd_chk("pol high", 8'hC2, 8'h03);
    host_u.write_reg(8'hC2, 8'h04);
    ticks(2);
    check("back to low", {7'h00, intr}, 8'h00);
    en = 8'h00;
    pix_cond = 1'b0;
    ticks(2);
    check("pix cond", {7'h00, pix_oe}, 8'h00);
    pix_cond = 1'b1;
    ticks(2);
    check("pix on", {7'h00, pix_oe}, 8'h01);
  endtask

  task automatic test_status_flags();
    logic [7:0] b;
    for (int i = 0; i < 6; i++)
    begin
      b = 8'h01 << i;
      svc = b[5:0];
      ticks(1);
      svc = 6'h00;
      rd_chk("flag set", 8'hC6, 8'h40 | b);
      host_u.write_reg(8'hC6, 8'h00);
      rd_chk("flag sticky", 8'hC6, 8'h40 | b);
      host_u.write_reg(8'hC6, b);
      rd_chk("flag cleared", 8'hC6, 8'h40);
    end
  endtask

  task automatic offer(input logic [8:0] n, input logic ok);
    line = '{req: 1'b1, bytes: n};
    ticks(1);
    line = '{req: 1'b0, bytes: ~n};
    ticks(1);
    check("accept", {7'h00, acc}, {7'h00, ok});
    check("reject", {7'h00, rej}, {7'h00, !ok});
  endtask

  task automatic test_fifo();
    offer(9'd10, 1'b1);
    rd_chk("words 10", 8'hC7, 8'h05);
    rd_chk("not empty", 8'hC6, 8'h00);
    offer(9'd10, 1'b0);
    rd_chk("full err", 8'hC6, 8'h80);
    rd_chk("words kept", 8'hC7, 8'h05);
    offer(9'd2, 1'b1);
    rd_chk("small line", 8'hC7, 8'h06);
    offer(9'd4, 1'b1);
    rd_chk("exact fit", 8'hC7, 8'h08);
    pop = 1'b1;
    ticks(1);
    pop = 1'b0;
    rd_chk("odd byte", 8'hC7, 8'h07);
    flush = 1'b1;
    ticks(1);
    flush = 1'b0;
    rd_chk("flushed", 8'hC6, 8'hC0);
    offer(9'd64, 1'b0);
    rd_chk("long line", 8'hC7, 8'h00);
    host_u.write_reg(8'hC6, 8'h80);
    rd_chk("err cleared", 8'hC6, 8'h40);
  endtask

  // accesses and captures while the enable is low must leave no trace
  task automatic test_ce_freeze();
    ce = 1'b0;
    host_u.write_reg(8'hC4, 8'h77);
    svc = 6'h01;
    ticks(1);
    svc = 6'h00;
    ce = 1'b1;
    rd_chk("frozen ptr", 8'hC4, 8'h01);
    rd_chk("frozen flags", 8'hC6, 8'h40);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // reset, then each scenario in turn
  initial
  begin
    arst_n = 1'b0;
    ce = 1'b1;
    pix_cond = 1'b1;
    pop = 1'b0;
    flush = 1'b0;
    svc = 6'h00;
    st = 8'h00;
    en = 8'h00;
    line = '0;
    repeat (8) @(posedge mclk);
    check("data reset", rdata, 8'hDC);
    #1;
    arst_n = 1'b1;
    ticks(3);
    test_reset_values();
    test_cfg_ram();
    test_intr_pin();
    test_status_flags();
    test_fifo();
    test_ce_freeze();
    end_of_test();
  end

  // hang guard, far beyond the expected run
  initial
  begin
    #(50 * 20000);
    bad_count++;
    end_of_test();
  end
endmodule // vbsr_top_tb
